// [rtl/ttp_defines.svh]
// ttp_defines.svh: bit positions, reset values and divider ratios for the timer trio
// assumes: included by bare name from rtl files
`ifndef TTP_DEFINES_SVH
`define TTP_DEFINES_SVH
`define TTP_MODE_RESET      8'h00
`define TTP_CNT_RESET       8'hFF
`define TTP_BIT_OUT_SRC     0
`define TTP_BIT_HALT        1
`define TTP_BIT_T1_PRE      2
`define TTP_BIT_T2_SRC      3
`define TTP_BIT_T3_SRC      4
`define TTP_BIT_POL         5
`define TTP_BIT_OUT_EN      6
`define TTP_BIT_LATCH_ONLY  7
`define TTP_SYS_DIV         8
`define TTP_SUB_DIV         2
`endif

// [rtl/ttp_pkg.sv]
// ttp_pkg.sv: shared types for the timer trio
// assumes: nothing beyond the defines header
package ttp_pkg;
  typedef logic [7:0] ttp_byte_t;
endpackage

// [rtl/ttp_down_timer.sv]
// ttp_down_timer.sv: one 8-bit down counter with reload latch
// assumes: write strobes are one-cycle pulses on clk; tick is a per-cycle enable that timer 2 holds high on the system clock
`timescale 1ns/100ps
`default_nettype none
`include "ttp_defines.svh"
module ttp_down_timer
  import ttp_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire logic      tick,
  input  wire logic      wr_en,
  input  wire logic      wr_latch_only,
  input  wire ttp_byte_t wr_data,
  output ttp_byte_t      count_ff,
  output ttp_byte_t      latch_ff,
  output logic           uflow_ff
);
  wire logic uflow_now;
  assign uflow_now = tick && (count_ff == 8'h00);

  // latch only changes on writes, never on a source change
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      latch_ff <= `TTP_CNT_RESET;
    else if (wr_en)
      latch_ff <= wr_data;
  end

  // a write wins over a concurrent tick so software reloads are exact
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      count_ff <= `TTP_CNT_RESET;
    else if (wr_en && !wr_latch_only)
      count_ff <= wr_data;
    else if (uflow_now)
      count_ff <= latch_ff;
    else if (tick)
      count_ff <= count_ff - 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      uflow_ff <= 1'b0;
    else
      uflow_ff <= uflow_now;
  end

  property p_reload;
    @(posedge clk) disable iff (!rst_n)
      (uflow_now && !wr_en) |=> (count_ff == $past(latch_ff)) && uflow_ff;
  endproperty
  a_reload: assert property (p_reload) else $error("no reload on underflow");
endmodule // ttp_down_timer
`default_nettype wire

// [rtl/ttp_timer_trio.sv]
// ttp_timer_trio.sv: three chained 8-bit timers with shared pulse output
// assumes: sub_clock_input is asynchronous and slower than clk/4; writes are 1-cycle strobes
// Operation
// - each underflow sets its request flag, reloads from latch, keeps counting
// - timer 1 counts system clock /8 or sub-clock /2
// - timer 1 pulse mode when output enable 1 and source select 0
// - timer 1 underflow in pulse mode toggles pin and sets its flag
// - toggling each underflow gives a 50 percent duty square wave
// - polarity 0 starts output high, 1 starts it low
// - timers 2 and 3 are 8-bit counters with 8-bit latches
// - latch-only bit 1 makes timer 2 writes update latch only
// - latch-only bit 0 makes timer 2 writes load counter and latch
// - source change keeps latch; software rewrites timer afterwards
// - timer 2 counts timer 1 underflows or undivided system clock
// - enable and source select both 1 make timer 2 toggle pin
// - timer 3 counts timer 1 underflows or system clock /8
// - timer 3 writes always load counter and latch
// - timer 1 is 8-bit counter with latch and pulse output
// - output enable drives waveform onto pin, 0 disconnects it
// - reset clears latch-only bit so writes load both
`timescale 1ns/100ps
`default_nettype none
`include "ttp_defines.svh"
module ttp_timer_trio
  import ttp_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire logic      sub_clock_input,
  input  wire logic      mode_wr,
  input  wire ttp_byte_t mode_wdata,
  input  wire logic      t1_wr,
  input  wire logic      t2_wr,
  input  wire logic      t3_wr,
  input  wire ttp_byte_t timer_wdata,
  input  wire logic      irq_clr_t1,
  input  wire logic      irq_clr_t2,
  input  wire logic      irq_clr_t3,
  output ttp_byte_t      timer_trio_mode_reg,
  output ttp_byte_t      t1_count,
  output ttp_byte_t      t2_count,
  output ttp_byte_t      t3_count,
  output logic           irq_t1_ff,
  output logic           irq_t2_ff,
  output logic           irq_t3_ff,
  output logic           pulse_output_pin,
  output logic           pulse_output_oe
);
  ttp_byte_t mode_ff;
  ttp_byte_t t2_latch, t3_latch;
  logic      t1_uf, t2_uf, t3_uf;
  logic      sub_s1_ff, sub_s2_ff, sub_s3_ff, sub_half_ff;
  logic [2:0] div8_ff;
  logic      div8_tick_ff, sub2_tick_ff;
  logic      wave_ff, oe_ff;

  wire logic output_source_select        = mode_ff[`TTP_BIT_OUT_SRC];
  wire logic timer_halt_bit              = mode_ff[`TTP_BIT_HALT];
  wire logic first_timer_prescale_select = mode_ff[`TTP_BIT_T1_PRE];
  wire logic second_timer_source_select  = mode_ff[`TTP_BIT_T2_SRC];
  wire logic third_timer_source_select   = mode_ff[`TTP_BIT_T3_SRC];
  wire logic output_polarity_bit         = mode_ff[`TTP_BIT_POL];
  wire logic output_enable_bit           = mode_ff[`TTP_BIT_OUT_EN];
  wire logic latch_only_write_bit        = mode_ff[`TTP_BIT_LATCH_ONLY];

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      mode_ff <= `TTP_MODE_RESET;
    else if (mode_wr)
      mode_ff <= mode_wdata;
  end
  assign timer_trio_mode_reg = mode_ff;

  // system clock /8 enable
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      div8_ff      <= 3'h0;
      div8_tick_ff <= 1'b0;
    end
    else
    begin
      div8_ff      <= div8_ff + 3'h1;
      div8_tick_ff <= (div8_ff == 3'(`TTP_SYS_DIV - 1));
    end
  end

  // sub-clock synchronised, rising edges halved: one tick per 2 sub-clock periods
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sub_s1_ff    <= 1'b0;
      sub_s2_ff    <= 1'b0;
      sub_s3_ff    <= 1'b0;
      sub_half_ff  <= 1'b0;
      sub2_tick_ff <= 1'b0;
    end
    else
    begin
      sub_s1_ff    <= sub_clock_input;
      sub_s2_ff    <= sub_s1_ff;
      sub_s3_ff    <= sub_s2_ff;
      sub2_tick_ff <= 1'b0;
      if (sub_s2_ff && !sub_s3_ff)
      begin
        sub_half_ff  <= ~sub_half_ff;
        sub2_tick_ff <= sub_half_ff;
      end
    end
  end

  wire logic t1_tick = !timer_halt_bit &&
                       (first_timer_prescale_select ? sub2_tick_ff : div8_tick_ff);
  wire logic t2_tick = second_timer_source_select ? 1'b1 : t1_uf;
  wire logic t3_tick = third_timer_source_select ? div8_tick_ff : t1_uf;

  ttp_down_timer u_t1 (
    .clk(clk), .rst_n(rst_n), .tick(t1_tick), .wr_en(t1_wr),
    .wr_latch_only(latch_only_write_bit), .wr_data(timer_wdata),
    .count_ff(t1_count), .latch_ff(), .uflow_ff(t1_uf));
  ttp_down_timer u_t2 (
    .clk(clk), .rst_n(rst_n), .tick(t2_tick), .wr_en(t2_wr),
    .wr_latch_only(latch_only_write_bit), .wr_data(timer_wdata),
    .count_ff(t2_count), .latch_ff(t2_latch), .uflow_ff(t2_uf));
  ttp_down_timer u_t3 (
    .clk(clk), .rst_n(rst_n), .tick(t3_tick), .wr_en(t3_wr),
    .wr_latch_only(1'b0), .wr_data(timer_wdata),
    .count_ff(t3_count), .latch_ff(t3_latch), .uflow_ff(t3_uf));

  // sticky request flags; a set in the clear cycle wins
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      irq_t1_ff <= 1'b0;
      irq_t2_ff <= 1'b0;
      irq_t3_ff <= 1'b0;
    end
    else
    begin
      irq_t1_ff <= t1_uf | (irq_t1_ff & ~irq_clr_t1);
      irq_t2_ff <= t2_uf | (irq_t2_ff & ~irq_clr_t2);
      irq_t3_ff <= t3_uf | (irq_t3_ff & ~irq_clr_t3);
    end
  end

  wire logic sel_uf = output_source_select ? t2_uf : t1_uf;
  wire logic start_level = ~output_polarity_bit;

  // while disabled the wave is held at its start level, so enabling starts clean;
  // the enabling write takes its polarity from the incoming byte, else it lags a cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      wave_ff <= 1'b1;
    else if (mode_wr && !output_enable_bit)
      wave_ff <= ~mode_wdata[`TTP_BIT_POL];
    else if (!output_enable_bit)
      wave_ff <= start_level;
    else if (sel_uf)
      wave_ff <= ~wave_ff;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      oe_ff <= 1'b0;
    else
      oe_ff <= output_enable_bit;
  end
  assign pulse_output_pin = wave_ff;
  assign pulse_output_oe  = oe_ff;

  property p_toggle;
    @(posedge clk) disable iff (!rst_n)
      (output_enable_bit && $past(output_enable_bit) && !mode_wr && sel_uf)
        |=> (wave_ff != $past(wave_ff));
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin did not toggle");

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      (output_enable_bit && !sel_uf && !mode_wr) |=> $stable(wave_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("pin moved without underflow");

  property p_start;
    @(posedge clk) disable iff (!rst_n)
      (!output_enable_bit && !mode_wr) |=> (wave_ff == ~output_polarity_bit);
  endproperty
  a_start: assert property (p_start) else $error("bad start level");

  property p_enable_start;
    @(posedge clk) disable iff (!rst_n)
      (mode_wr && !output_enable_bit && mode_wdata[`TTP_BIT_OUT_EN])
        |=> (wave_ff == ~$past(mode_wdata[`TTP_BIT_POL]));
  endproperty
  a_enable_start: assert property (p_enable_start) else $error("bad level at enable");

  property p_halt;
    @(posedge clk) disable iff (!rst_n)
      (timer_halt_bit && !t1_wr && !mode_wr) |=> $stable(t1_count);
  endproperty
  a_halt: assert property (p_halt) else $error("timer 1 ran while halted");

  property p_t2_free;
    @(posedge clk) disable iff (!rst_n)
      (second_timer_source_select && !t2_wr && t2_count != 8'h00)
        |=> (t2_count == $past(t2_count) - 8'h01);
  endproperty
  a_t2_free: assert property (p_t2_free) else $error("timer 2 not on clock");

  property p_t3_write;
    @(posedge clk) disable iff (!rst_n)
      t3_wr |=> (t3_count == $past(timer_wdata)) && (t3_latch == $past(timer_wdata));
  endproperty
  a_t3_write: assert property (p_t3_write) else $error("timer 3 write lost");

  property p_t2_latch_only;
    @(posedge clk) disable iff (!rst_n)
      (t2_wr && latch_only_write_bit && !t2_tick) |=> $stable(t2_count);
  endproperty
  a_t2_latch_only: assert property (p_t2_latch_only) else $error("counter written");

  property p_t2_latch_write;
    @(posedge clk) disable iff (!rst_n)
      t2_wr |=> (t2_latch == $past(timer_wdata));
  endproperty
  a_t2_latch_write: assert property (p_t2_latch_write) else $error("t2 latch lost");

  property p_irq_set;
    @(posedge clk) disable iff (!rst_n)
      t3_uf |=> irq_t3_ff;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("timer 3 flag not set");
endmodule // ttp_timer_trio
`default_nettype wire

// [tb/ttp_timer_trio_bench.sv]
// ttp_timer_trio_bench.sv: self-checking bench for the timer trio
// assumes: design compiled from rtl/, inputs driven on the falling clock edge
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module ttp_timer_trio_bench
  import ttp_pkg::*;
;
  logic      clk;
  logic      rst_n;
  logic      sub_clock_input = 1'b0;
  logic      mode_wr;
  ttp_byte_t mode_wdata;
  logic      t1_wr;
  logic      t2_wr;
  logic      t3_wr;
  ttp_byte_t timer_wdata;
  logic      irq_clr_t1;
  logic      irq_clr_t2;
  logic      irq_clr_t3;
  ttp_byte_t timer_trio_mode_reg;
  ttp_byte_t t1_count;
  ttp_byte_t t2_count;
  ttp_byte_t t3_count;
  logic      irq_t1_ff;
  logic      irq_t2_ff;
  logic      irq_t3_ff;
  logic      pulse_output_pin;
  logic      pulse_output_oe;
  logic      sub_run;
  int        sub_cnt = 0;
  int        cyc = 0;
  int        n_errors;
  int        num_checks;

  ttp_timer_trio i_ttp_timer_trio (.clk(clk), .rst_n(rst_n), .sub_clock_input(sub_clock_input),
    .mode_wr(mode_wr), .mode_wdata(mode_wdata), .t1_wr(t1_wr), .t2_wr(t2_wr), .t3_wr(t3_wr),
    .timer_wdata(timer_wdata), .irq_clr_t1(irq_clr_t1), .irq_clr_t2(irq_clr_t2),
    .irq_clr_t3(irq_clr_t3), .timer_trio_mode_reg(timer_trio_mode_reg), .t1_count(t1_count),
    .t2_count(t2_count), .t3_count(t3_count), .irq_t1_ff(irq_t1_ff), .irq_t2_ff(irq_t2_ff),
    .irq_t3_ff(irq_t3_ff), .pulse_output_pin(pulse_output_pin),
    .pulse_output_oe(pulse_output_oe));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // sub-clock period of 8 system clocks keeps it well below the clk/4 limit
  always @(negedge clk)
  begin
    sub_cnt <= sub_run ? sub_cnt + 1 : 0;
    if (sub_run && sub_cnt % 4 == 3)
      sub_clock_input <= ~sub_clock_input;
  end

  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // cycle count read by the watchdog branch of the main sequence
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
  end

  function automatic logic sig(input int w);
    case (w)
      1: return irq_t1_ff;
      2: return irq_t2_ff;
      3: return irq_t3_ff;
      default: return pulse_output_pin;
    endcase
  endfunction

  // k 0 writes the mode byte, 1..3 the matching timer
  task automatic wr(input int k, input ttp_byte_t d);
    @(negedge clk);
    mode_wdata = d;
    timer_wdata = d;
    mode_wr = (k == 0);
    t1_wr = (k == 1);
    t2_wr = (k == 2);
    t3_wr = (k == 3);
    @(negedge clk);
    {mode_wr, t1_wr, t2_wr, t3_wr} = 4'h0;
  endtask

  // pin: cycles to next toggle; flags: cycles to next set, cleared after each hit
  task automatic edge_wait(input int w, output int n);
    logic r;
    r = (w == 0) ? pulse_output_pin : 1'b0;
    n = 0;
    do
    begin
      @(negedge clk);
      {irq_clr_t3, irq_clr_t2, irq_clr_t1} = 3'b000;
      n++;
    end
    while (sig(w) === r && n < 300);
    if (w != 0)
      {irq_clr_t3, irq_clr_t2, irq_clr_t1} = 3'b001 << (w - 1);
  endtask

  // two intervals in a row must match, which also proves an even duty on the pin;
  // two events are skipped first, as a stale flag makes the first interval short
  task automatic gap(input int w, input int exp, input string nm);
    int n;
    edge_wait(w, n);
    edge_wait(w, n);
    edge_wait(w, n);
    `CHK(nm, exp, n)
    edge_wait(w, n);
    `CHK(nm, exp, n)
    @(negedge clk);
    {irq_clr_t3, irq_clr_t2, irq_clr_t1} = 3'b000;
  endtask

  task automatic t_reset_and_writes;
    `CHK("mode", 8'h00, timer_trio_mode_reg)
    `CHK("t1", 8'hFF, t1_count)
    `CHK("pin", 1'b1, pulse_output_pin)
    `CHK("oe", 1'b0, pulse_output_oe)
    wr(0, 8'h82);
    wr(3, 8'h05);
    `CHK("t3", 8'h05, t3_count)
    wr(0, 8'h02);
    wr(2, 8'h03);
    `CHK("t2", 8'h03, t2_count)
    wr(0, 8'h82);
    wr(2, 8'h10);
    `CHK("t2", 8'h03, t2_count)
    wr(0, 8'h02);
    wr(1, 8'h40);
    repeat (40) @(negedge clk);
    `CHK("t1", 8'h40, t1_count)
  endtask

  task automatic t_timer2_pulse;
    wr(2, 8'h03);
    wr(0, 8'h63);
    @(negedge clk);
    `CHK("pin", 1'b0, pulse_output_pin)
    `CHK("oe", 1'b1, pulse_output_oe)
    wr(0, 8'h4B);
    gap(0, 4, "t2 pin");
    wr(0, 8'h43);
    wr(0, 8'h4B);
    gap(2, 4, "t2 irq");
    wr(0, 8'hCB);
    wr(2, 8'h07);
    gap(0, 8, "t2 pin");
    wr(0, 8'h0B);
    @(negedge clk);
    `CHK("oe", 1'b0, pulse_output_oe)
    `CHK("pin", 1'b1, pulse_output_pin)
  endtask

  task automatic t_timer1_chain;
    wr(0, 8'h02);
    wr(1, 8'h01);
    wr(3, 8'h01);
    wr(0, 8'h40);
    gap(0, 16, "t1 pin");
    gap(1, 16, "t1 irq");
    gap(3, 32, "t3 irq");
    wr(0, 8'h10);
    wr(3, 8'h02);
    gap(3, 24, "t3 irq");
    wr(0, 8'h00);
    wr(1, 8'h00);
    wr(2, 8'h01);
    gap(2, 16, "t2 irq");
    sub_run = 1'b1;
    wr(0, 8'h44);
    wr(1, 8'h01);
    gap(0, 32, "sub pin");
    sub_run = 1'b0;
  endtask

  initial
  begin
    {rst_n, mode_wr, t1_wr, t2_wr, t3_wr, sub_run} = 6'h00;
    {irq_clr_t1, irq_clr_t2, irq_clr_t3} = 3'b000;
    mode_wdata = 8'h00;
    timer_wdata = 8'h00;
    n_errors = 0;
    num_checks = 0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    // the watchdog races the scenarios so a hang still reaches the verdict
    fork
      begin
        t_reset_and_writes();
        t_timer2_pulse();
        t_timer1_chain();
      end
      wait (cyc >= 5000);
    join_any
    if (cyc >= 5000)
      n_errors++;
    summarize();
  end
endmodule // ttp_timer_trio_bench
`default_nettype wire
